// File: bla_defines.vh
// bla_defines.vh: offsets, field positions, reset values and timing counts for the boot loader autobaud block
// assumes: included by bare name from the boot loader design file; the fifo file does not include it
`ifndef BLA_DEFINES_VH
`define BLA_DEFINES_VH

// clock
`define BLA_CLK_PERIOD_NS   4

// axi4-lite register byte offsets
`define BLA_OFF_CTRL        8'h00
`define BLA_OFF_STATUS      8'h04
`define BLA_OFF_TIMER       8'h08
`define BLA_OFF_RELOAD      8'h0C
`define BLA_RESP_OKAY       2'h0
`define BLA_RESP_SLVERR     2'h2

// ctrl fields (write one to trigger)
`define BLA_CTRL_SWRST      0

// status fields
`define BLA_ST_BOOT_MODE    0
`define BLA_ST_OVERFLOW     1
`define BLA_ST_OVERRUN      2
`define BLA_ST_FRAME_ERR    3
`define BLA_ST_JUMPED       4
`define BLA_ST_STATE_LSB    8

// reload arithmetic and baud timing
`define BLA_RELOAD_SUB      16'h0024
`define BLA_RELOAD_DIV      16'h0048
`define BLA_BAUD_SHIFT      5
`define BLA_TMR_PRESC_MAX   2'h3

// load sequence and fetch addresses
`define BLA_LOAD_BYTES      6'h20
`define BLA_LOAD_BASE       24'h00FA40
`define BLA_RESET_FETCH     24'h000000

`endif

// File: bla_fifo.v
// bla_fifo: small first-in first-out buffer, register array storage
// assumes: one clock, synchronous active-low reset, both sides on the same clock
`default_nettype none

module bla_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  // full and empty straight from the occupancy count
  assign in_ready  = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_ptr_q];

  // storage has no reset: contents are only read while count says valid
  always @(posedge aclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers wrap at depth, so depth must be a power of two
  always @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule // bla_fifo

`default_nettype wire

// File: bla_boot_loader.v
// bla_boot_loader: serial bootstrap loader with automatic baud detection and axi4-lite status port
// assumes: pins arrive asynchronous to aclk; ram write port and cpu start sit on aclk
// How it works
// - A software reset through the control register always leaves boot-loader mode, whatever the strap.
// - After a hardware reset boot-loader mode is entered only when the boot select strap reads low.
// - On leaving boot-loader mode through reset the fetch address is zero, internal or external per the access pin.
// - One serial bit lasts 32 times (reload plus one) cpu clocks.
// - The zero byte timer counts the calibration byte in steps of four cpu clocks.
// - The reload value is the timer count minus 36, divided by 72.
// - The zero byte timer is 16 bits wide; running past its top sets a sticky overflow flag.
// - After the rate is derived the transmit pin is enabled and an identification byte is sent.
// - Then 32 bytes are received, written upward from 00FA40h, and execution jumps there.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`default_nettype none
`include "bla_defines.vh"

module bla_boot_loader #(
  parameter [7:0] ID_BYTE = 8'hA5, // identification value, arbitrary
  parameter       FIFO_DEPTH = 4
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        boot_select_strap,
  input  wire        external_access_pin,
  input  wire        serial_receive_pin,
  output wire        serial_transmit_pin,
  output wire        serial_transmit_oe,
  output wire        boot_loader_mode,
  output wire        cpu_start,
  output wire [23:0] fetch_addr,
  output wire        fetch_external,
  output wire        ram_we,
  input  wire        ram_ready,
  output wire [23:0] ram_addr,
  output wire [7:0]  ram_wdata,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready
);

  // one-hot loader states
  localparam [7:0] ST_WAIT   = 8'h01;
  localparam [7:0] ST_MEAS   = 8'h02;
  localparam [7:0] ST_CALC   = 8'h04;
  localparam [7:0] ST_TXID   = 8'h08;
  localparam [7:0] ST_LOAD   = 8'h10;
  localparam [7:0] ST_RUN    = 8'h20;
  localparam [7:0] ST_NORMAL = 8'h40;
  localparam [7:0] ST_STRAP  = 8'h80;

  // reload from timer count, truncating; counts under the offset give zero
  function [15:0] calc_reload;
    input [15:0] t;
    begin
      if (t < `BLA_RELOAD_SUB) begin
        calc_reload = 16'h0000;
      end else begin
        calc_reload = (t - `BLA_RELOAD_SUB) / `BLA_RELOAD_DIV;
      end
    end
  endfunction

  // cpu clocks per serial bit
  function [20:0] bit_len;
    input [15:0] rl;
    begin
      bit_len = {5'h00, rl + 16'h0001} << `BLA_BAUD_SHIFT;
    end
  endfunction

  reg [7:0]  state_q;
  reg        boot_q;
  reg        start_q;
  reg [23:0] fetch_q;
  reg [15:0] timer_q;
  reg [1:0]  presc_q;
  reg [15:0] reload_q;
  reg        ovf_q, overrun_q, ferr_q, jumped_q;
  reg        rx_m_q, rx_s_q, rx_d_q;
  reg        strap_m_q, strap_s_q;
  reg        acc_m_q, acc_s_q;
  reg        wstrb0_q;
  reg        tx_done_q;
  reg        tx_line_q, tx_oe_q;
  reg [9:0]  tx_sh_q;
  reg [3:0]  tx_bits_q;
  reg [20:0] tx_cnt_q;
  reg        rx_busy_q;
  reg [3:0]  rx_bit_q;
  reg [20:0] rx_cnt_q;
  reg [7:0]  rx_sh_q;
  reg        rx_push_q;
  reg [5:0]  rx_bytes_q;
  reg [5:0]  wr_bytes_q;
  reg [23:0] ram_addr_q;
  reg        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q, rdata_q;
  reg [1:0]  bresp_q, rresp_q;

  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire       rx_fall = rx_d_q && !rx_s_q;
  wire       rx_rise = !rx_d_q && rx_s_q;
  wire [20:0] blen = bit_len(reload_q);

  // pin synchronisers: second stage is the only reader of the first
  always @(posedge aclk) begin
    rx_m_q    <= serial_receive_pin;
    rx_s_q    <= rx_m_q;
    strap_m_q <= boot_select_strap;
    strap_s_q <= strap_m_q;
    acc_m_q   <= external_access_pin;
    acc_s_q   <= acc_m_q;
  end

  // axi write: address and data taken in either order, response once both are held
  wire aw_take = s_axi_awvalid && !aw_hold_q && !bvalid_q;
  wire w_take  = s_axi_wvalid && !w_hold_q && !bvalid_q;
  wire wr_go   = aw_hold_q && w_hold_q && !bvalid_q;
  wire sw_rst  = wr_go && (awaddr_q == `BLA_OFF_CTRL) && wstrb0_q && wdata_q[`BLA_CTRL_SWRST];
  assign s_axi_awready = aw_take;
  assign s_axi_wready  = w_take;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `BLA_RESP_OKAY;
      awaddr_q  <= 8'h00;
      wdata_q   <= 32'h00000000;
      wstrb0_q  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        // status, timer and reload are read-only; writes there are accepted and dropped
        case (awaddr_q)
          `BLA_OFF_CTRL, `BLA_OFF_STATUS, `BLA_OFF_TIMER, `BLA_OFF_RELOAD: bresp_q <= `BLA_RESP_OKAY;
          default: bresp_q <= `BLA_RESP_SLVERR;
        endcase
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // axi read: one cycle from address to data
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `BLA_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rresp_q  <= `BLA_RESP_OKAY;
      case (s_axi_araddr)
        `BLA_OFF_CTRL:   rdata_q <= 32'h00000000;
        `BLA_OFF_STATUS: rdata_q <= {16'h0000, state_q, 3'h0, jumped_q, ferr_q, overrun_q, ovf_q, boot_q};
        `BLA_OFF_TIMER:  rdata_q <= {16'h0000, timer_q};
        `BLA_OFF_RELOAD: rdata_q <= {16'h0000, reload_q};
        default: begin
          rdata_q <= 32'h00000000;
          rresp_q <= `BLA_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // loader sequence; first cycle after hardware reset release samples the strap
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q  <= ST_STRAP;
      boot_q   <= 1'b0;
      start_q  <= 1'b0;
      fetch_q  <= `BLA_RESET_FETCH;
      timer_q  <= 16'h0000;
      presc_q  <= 2'h0;
      reload_q <= 16'h0000;
      ovf_q    <= 1'b0;
      jumped_q <= 1'b0;
      tx_oe_q  <= 1'b0;
      rx_d_q   <= 1'b1;
    end else begin
      rx_d_q  <= rx_s_q;
      start_q <= 1'b0;
      if (sw_rst) begin
        state_q <= ST_NORMAL;
        boot_q  <= 1'b0;
        tx_oe_q <= 1'b0;
        fetch_q <= `BLA_RESET_FETCH;
        start_q <= 1'b1;
      end else begin
        case (state_q)
          ST_STRAP: begin
            start_q <= strap_s_q;
            boot_q  <= !strap_s_q;
            state_q <= strap_s_q ? ST_NORMAL : ST_WAIT;
          end
          ST_WAIT: begin
            if (rx_fall) begin
              state_q <= ST_MEAS;
              timer_q <= 16'h0000;
              presc_q <= 2'h0;
            end
          end
          ST_MEAS: begin
            presc_q <= presc_q + 2'h1;
            if (presc_q == `BLA_TMR_PRESC_MAX) begin
              timer_q <= timer_q + 16'h0001;
              if (timer_q == 16'hFFFF) begin
                ovf_q <= 1'b1;
              end
            end
            if (rx_rise) begin
              state_q <= ST_CALC;
            end
          end
          ST_CALC: begin
            reload_q <= calc_reload(timer_q);
            tx_oe_q  <= 1'b1;
            state_q  <= ST_TXID;
          end
          ST_TXID: begin
            if (tx_bits_q == 4'h0 && tx_done_q) begin
              state_q <= ST_LOAD;
            end
          end
          ST_LOAD: begin
            if (wr_bytes_q == `BLA_LOAD_BYTES) begin
              state_q  <= ST_RUN;
              fetch_q  <= `BLA_LOAD_BASE;
              start_q  <= 1'b1;
              jumped_q <= 1'b1;
            end
          end
          ST_RUN: state_q <= ST_RUN;
          ST_NORMAL: state_q <= ST_NORMAL;
          default: state_q <= ST_STRAP;
        endcase
      end
    end
  end

  assign boot_loader_mode = boot_q;
  assign cpu_start        = start_q;
  assign fetch_addr       = fetch_q;
  assign fetch_external   = !acc_s_q; // low access pin selects external memory

  // transmitter: one frame of start, id byte, stop at the derived rate
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_line_q <= 1'b1;
      tx_sh_q   <= 10'h3FF;
      tx_bits_q <= 4'h0;
      tx_cnt_q  <= 21'h000000;
      tx_done_q <= 1'b0;
    end else if (state_q == ST_CALC) begin
      tx_sh_q   <= {1'b1, ID_BYTE, 1'b0};
      tx_bits_q <= 4'hA;
      tx_cnt_q  <= 21'h000000;
      tx_done_q <= 1'b0;
    end else if (tx_cnt_q != 21'h000000) begin
      tx_cnt_q <= tx_cnt_q - 21'h000001;
    end else if (tx_bits_q != 4'h0) begin
      tx_line_q <= tx_sh_q[0];
      tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
      tx_bits_q <= tx_bits_q - 4'h1;
      tx_cnt_q  <= blen - 21'h000001;
    end else begin
      tx_done_q <= (state_q == ST_TXID);
    end
  end

  assign serial_transmit_pin = tx_line_q;
  assign serial_transmit_oe  = tx_oe_q;

  // receiver: mid-bit sampling; a byte the full fifo cannot take is lost and flagged
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_busy_q  <= 1'b0;
      rx_bit_q   <= 4'h0;
      rx_cnt_q   <= 21'h000000;
      rx_sh_q    <= 8'h00;
      rx_push_q  <= 1'b0;
      rx_bytes_q <= 6'h00;
      overrun_q  <= 1'b0;
      ferr_q     <= 1'b0;
    end else begin
      rx_push_q <= 1'b0;
      // count a byte only once the fifo has taken it, so a lost byte cannot stall the writer
      if (rx_push_q) begin
        if (fifo_in_ready) begin
          rx_bytes_q <= rx_bytes_q + 6'h01;
        end else begin
          overrun_q <= 1'b1;
        end
      end
      if (!rx_busy_q) begin
        if (state_q == ST_LOAD && rx_fall && rx_bytes_q != `BLA_LOAD_BYTES) begin
          rx_busy_q <= 1'b1;
          rx_bit_q  <= 4'h0;
          rx_cnt_q  <= {1'b0, blen[20:1]};
        end
      end else if (rx_cnt_q != 21'h000000) begin
        rx_cnt_q <= rx_cnt_q - 21'h000001;
      end else if (rx_bit_q == 4'h0) begin
        rx_busy_q <= !rx_s_q; // false start is dropped
        rx_bit_q  <= 4'h1;
        rx_cnt_q  <= blen - 21'h000001;
      end else if (rx_bit_q != 4'h9) begin
        rx_sh_q  <= {rx_s_q, rx_sh_q[7:1]};
        rx_bit_q <= rx_bit_q + 4'h1;
        rx_cnt_q <= blen - 21'h000001;
      end else begin
        rx_busy_q <= 1'b0;
        if (!rx_s_q) begin
          ferr_q <= 1'b1;
        end else begin
          rx_push_q <= 1'b1;
        end
      end
    end
  end

  bla_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (2)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (rx_push_q),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_sh_q),
    .out_valid (fifo_out_valid),
    .out_ready (ram_ready),
    .out_data  (fifo_out_data)
  );

  // ram writer: sequential addresses from the load base, stalled by ram_ready
  assign ram_we    = fifo_out_valid;
  assign ram_addr  = ram_addr_q;
  assign ram_wdata = fifo_out_data;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ram_addr_q <= `BLA_LOAD_BASE;
      wr_bytes_q <= 6'h00;
    end else if (fifo_out_valid && ram_ready) begin
      ram_addr_q <= ram_addr_q + 24'h000001;
      wr_bytes_q <= wr_bytes_q + 6'h01;
    end
  end

endmodule // bla_boot_loader

`default_nettype wire

// File: bla_boot_loader_asserts.sv
// bla_boot_loader_asserts: port-level checks of the boot loader
// assumes: bound into bla_boot_loader, one clock domain
`default_nettype none
module bla_boot_loader_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        boot_select_strap,
  input wire logic        external_access_pin,
  input wire logic        serial_transmit_oe,
  input wire logic        boot_loader_mode,
  input wire logic        cpu_start,
  input wire logic [23:0] fetch_addr,
  input wire logic        fetch_external,
  input wire logic        ram_we,
  input wire logic        ram_ready,
  input wire logic [23:0] ram_addr,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic aw_ctrl_q;
  logic w_one_q;

  // remember whether the write under way is a software reset
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready)
      aw_ctrl_q <= (s_axi_awaddr == 8'h00);
    if (s_axi_wvalid && s_axi_wready)
      w_one_q <= s_axi_wdata[0] && s_axi_wstrb[0];
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_strap_hi_run: assert property (
    $rose(aresetn) && boot_select_strap |-> ##[0:2]
    (cpu_start && !boot_loader_mode && fetch_addr == 24'h000000)) else $error("strap high did not start at zero");
  a_strap_lo_boot: assert property (
    $rose(aresetn) && !boot_select_strap |-> ##[0:2] boot_loader_mode) else $error("strap low did not enter boot mode");
  a_swrst_exit: assert property (
    $rose(s_axi_bvalid) && aw_ctrl_q && w_one_q |-> ##[0:2]
    (cpu_start && !boot_loader_mode && fetch_addr == 24'h000000)) else $error("software reset did not leave boot mode");
  a_load_jump: assert property (
    cpu_start && boot_loader_mode |-> fetch_addr == 24'h00FA40 && ram_addr == 24'h00FA60)
    else $error("jump after load is wrong");
  a_ram_step: assert property (
    ram_we && ram_ready |=> ram_addr == $past(ram_addr) + 24'h000001) else $error("ram address did not step by one");
  a_oe_in_boot: assert property (
    serial_transmit_oe |-> boot_loader_mode) else $error("transmit driven outside boot mode");
  a_ext_follow: assert property (
    $stable(external_access_pin) [*4] |-> fetch_external == !external_access_pin) else $error("fetch select wrong");
  a_rd_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C |=>
    s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");

  // main scenarios seen
  c_load_jump: cover property (cpu_start && boot_loader_mode);
  c_ram_stall: cover property (ram_we && !ram_ready);
  c_tx_on: cover property ($rose(serial_transmit_oe));
endmodule // bla_boot_loader_asserts

bind bla_boot_loader bla_boot_loader_asserts i_chk (.*);
`default_nettype wire

// File: bla_host_model.sv
// bla_host_model: host side of the serial boot link
// assumes: bit time in aclk cycles, receive line idles high
`default_nettype none
module bla_host_model #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic       aclk,
  input  wire logic       txd,
  input  wire logic       txd_oe,
  output var  logic       rxd,
  output var  logic [7:0] got,
  output var  logic       got_v
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  initial got_v = 1'b0;

  // one 8n1 frame, lsb first, at the derived rate
  task automatic send_byte(input logic [7:0] b);
    rxd <= 1'b0; // start bit
    repeat (BIT_CLKS) @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      rxd <= (i < 8) ? b[i] : 1'b1;
      repeat (BIT_CLKS) @(posedge aclk);
    end
  endtask

  // sample the reply mid-bit while the device drives its pin
  always begin
    @(negedge txd iff txd_oe);
    repeat (BIT_CLKS / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge aclk);
      got[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge aclk);
    got_v <= txd; // a low stop bit drops the byte
    @(posedge aclk);
    got_v <= 1'b0;
  end
endmodule // bla_host_model
`default_nettype wire

// File: bla_boot_loader_tb.sv
// bla_boot_loader_tb: self-checking bench for the serial boot loader
// assumes: design, host model and checker compiled before this file
`default_nettype none
module bla_boot_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         BIT_CLKS = 64;    // reload 1 gives 32*(1+1) clocks
  localparam logic [7:0] ID       = 8'h3C; // identification value, arbitrary
  logic        aclk = 1'b0;
  logic        aresetn, boot_select_strap, external_access_pin, serial_receive_pin;
  logic        serial_transmit_pin, serial_transmit_oe, boot_loader_mode, cpu_start;
  logic        fetch_external, ram_we, ram_ready, got_v, rdy_en;
  logic [23:0] fetch_addr, ram_addr, k;
  logic [7:0]  ram_wdata, s_axi_awaddr, s_axi_araddr, got, b;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] q_ram[$];
  logic [33:0] q_rd[$];
  logic [23:0] q_fa[$];
  logic [7:0]  q_id[$];
  logic [1:0]  q_b[$];
  int          error_cnt = 0;
  int          check_count = 0;

  bla_boot_loader #(.ID_BYTE(ID), .FIFO_DEPTH(4)) i_bla_boot_loader (.*);
  bla_host_model #(.BIT_CLKS(BIT_CLKS)) i_bla_host_model (.aclk(aclk), .txd(serial_transmit_pin),
    .txd_oe(serial_transmit_oe), .rxd(serial_receive_pin), .got(got), .got_v(got_v));

  always #2 aclk = ~aclk;

  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // hardware reset held 20 cycles with the strap at s
  task automatic rst(input logic s);
    @(posedge aclk);
    aresetn <= 1'b0;
    boot_select_strap <= s;
    repeat (20) @(posedge aclk);
    if (s) q_fa.push_back(24'h000000);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask

  // axi4-lite write; address and data released as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    q_b.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // axi4-lite read; expected {resp, data} noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge aclk);
    q_rd.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // ram side stalls at random once enabled, so the fifo backs up
  always @(posedge aclk) ram_ready <= rdy_en && $urandom_range(1, 0);

  // compare each result with the oldest note as it appears
  always @(posedge aclk) begin
    if (ram_we && ram_ready)
      chk("ram", {ram_addr, ram_wdata}, q_ram.size() ? q_ram.pop_front() : 'x);
    if (cpu_start)
      chk("fetch", fetch_addr, q_fa.size() ? q_fa.pop_front() : 'x);
    if (got_v)
      chk("id", got, q_id.size() ? q_id.pop_front() : 'x);
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", s_axi_bresp, q_b.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", {s_axi_rresp, s_axi_rdata}, q_rd.pop_front());
  end

  // watchdog: a full load takes about 21000 cycles
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    close_out();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rdy_en} = '0;
    {boot_select_strap, external_access_pin, s_axi_awaddr, s_axi_araddr} = {2'b10, 16'h0};
    {s_axi_wdata, s_axi_wstrb} = '0;
    void'($urandom(84));
    rst(1'b1);
    chk("mode", boot_loader_mode, 1'b0);
    chk("ext", fetch_external, 1'b1);
    rd(8'h00, 34'h0);
    rd(8'h10, {2'h2, 32'h0});
    wr(8'h14, 32'h1, 2'h2);
    external_access_pin <= 1'b1;
    rst(1'b0);
    chk("mode", boot_loader_mode, 1'b1);
    chk("ext", fetch_external, 1'b0);
    q_id.push_back(ID);
    i_bla_host_model.send_byte(8'h00);
    while (!got_v) @(posedge aclk);
    // got_v comes mid stop bit; the receiver opens only once that stop bit is over
    repeat (BIT_CLKS) @(posedge aclk);
    rd(8'h0C, 34'h1);
    chk("oe", serial_transmit_oe, 1'b1);
    // fifo of 4 fills while the ram stalls; the fifth byte is lost
    q_fa.push_back(24'h00FA40);
    k = 24'h00FA40;
    for (int i = 0; i < 33; i++) begin
      b = $urandom;
      if (i != 4) begin
        q_ram.push_back({k, b});
        k = k + 24'h000001;
      end
      i_bla_host_model.send_byte(b);
      rdy_en <= (i >= 4);
    end
    while (q_fa.size() != 0) @(posedge aclk);
    rd(8'h04, {2'h0, 32'h0000_2015});
    q_fa.push_back(24'h000000);
    wr(8'h00, 32'h1, 2'h0);
    repeat (3) @(posedge aclk);
    chk("mode", boot_loader_mode, 1'b0);
    chk("oe", serial_transmit_oe, 1'b0);
    repeat (3) @(posedge aclk);
    chk("left", q_ram.size() + q_id.size() + q_fa.size(), 0);
    close_out();
  end
endmodule // bla_boot_loader_tb
`default_nettype wire
